// file: verilog/lcdd_cfg.svh
// constants of the lcd instruction decoder
`ifndef LCDD_CFG_SVH
`define LCDD_CFG_SVH
`define LCDD_CLK_NS 100
`define LCDD_BUSY_NS 200
`define LCDD_INIT_NS 1000
`define LCDD_OP_DISP 7'h57
`define LCDD_OP_ADC 7'h50
`define LCDD_OP_STATIC 7'h52
`define LCDD_OP_DUTY 7'h54
`define LCDD_OP_LINE 3'h6
`define LCDD_OP_PAGE 6'h2E
`define LCDD_OP_COL 1'b0
`define LCDD_CMD_RMW 8'hE0
`define LCDD_CMD_END 8'hEE
`define LCDD_CMD_SRST 8'hE2
`define LCDD_F_OP7 7:1
`define LCDD_F_OP6 7:2
`define LCDD_F_OP3 7:5
`define LCDD_F_MSB 7
`define LCDD_F_D0 0
`define LCDD_F_LINE 4:0
`define LCDD_F_PAGE 1:0
`define LCDD_F_COL 6:0
`define LCDD_F_LBIT 2:0
`define LCDD_F_LPAGE 4:3
`define LCDD_COL_STOP 7'h50
`define LCDD_COL_LAST 7'h4F
`define LCDD_COL_INIT 7'h00
`define LCDD_PAGE_INIT 2'h3
`define LCDD_LINE_INIT 5'h00
`define LCDD_LINES16 6'h10
`define LCDD_LINES32 6'h20
`define LCDD_COM_LAST16 5'h0F
`define LCDD_STAT_LOW 4'h0
`define LCDD_COM_ONE 32'h0000_0001
`define LCDD_PIN_RSTN 3
`define LCDD_PIN_A0 2
`define LCDD_PIN_SA 1
`define LCDD_PIN_SB 0
`endif

// file: verilog/lcdd_pkg.sv
// types of the lcd instruction decoder
`default_nettype none
package lcdd_pkg;
	typedef enum logic [1:0] {
		LCDD_PH_IDLE = 2'h0,
		LCDD_PH_WR = 2'h1,
		LCDD_PH_RD = 2'h2
	} lcdd_phase_type;
endpackage
`default_nettype wire

// file: verilog/lcdd_ram.sv
// display memory: pages of columns of bytes, one write and two read ports
`timescale 1ns/100ps
`default_nettype none
module lcdd_ram #(
	parameter int COLS = 80,
	parameter int PAGES = 4
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [1:0] wr_page,
	input wire logic [6:0] wr_col,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] hr_page,
	input wire logic [6:0] hr_col,
	output logic [7:0] hr_data,
	input wire logic [1:0] sr_page,
	input wire logic [6:0] sr_col,
	output logic [7:0] sr_data
);
	localparam int DEPTH = COLS * PAGES;
	if (COLS < 1 || COLS > 80 || PAGES < 1 || PAGES > 4) begin : g_bad
		$error("lcdd_ram: geometry out of range");
	end
	logic [7:0] mem_q [DEPTH];
	logic [8:0] w_idx, h_idx, s_idx;
	always_comb begin
		w_idx = 9'(int'(wr_page) * COLS + int'(wr_col));
		h_idx = 9'(int'(hr_page) * COLS + int'(hr_col));
		s_idx = 9'(int'(sr_page) * COLS + int'(sr_col));
		hr_data = (int'(hr_col) < COLS && int'(hr_page) < PAGES) ? mem_q[h_idx] : 8'h00;
		sr_data = (int'(sr_col) < COLS && int'(sr_page) < PAGES) ? mem_q[s_idx] : 8'h00;
	end
	// columns past the last one are dropped
	always_ff @(posedge clock) begin
		if (wr_en && int'(wr_col) < COLS && int'(wr_page) < PAGES) begin
			mem_q[w_idx] <= wr_data;
		end
	end
endmodule
`default_nettype wire

// file: verilog/lcdd_decoder.sv
// instruction decoder of a bitmap lcd driver with host bus and display scan
`timescale 1ns/100ps
`default_nettype none
`include "lcdd_cfg.svh"
// Behaviour
// - select line picks data or command/status; strobe gives direction
// - on/off command lowest bit switches whole display
// - static on while off, or off while static, enters power save
// - display on or static off leaves power save; data and modes kept
// - start line loads five bits; that line drives first common
// - rows shown run from start line for duty lines
// - page command loads page 0 to 3 for host access
// - page changes never alter the displayed image
// - column auto-increments, stops at 50 hex, page unchanged
// - data write stores byte at page and column, then increments column
// - data read returns byte at current page and column
// - outside rmw, data read increments column afterwards
// - writes pass a holding latch, committed on next write; reads pipelined
// - status is busy, order, off, reset flags over four zero bits
// - busy reads 1 during an operation or reset cycle
// - order flag 0 maps column 79-n to segment n, else n
// - order command reverses column to segment mapping
// - display flag reads inverse of on/off command bit
// - reset flag reads 1 during pin or command initialization
// - static drive forces all commons and whole display on while display is on; with display off power save holds them low
// - duty bit 1 selects 1/32, 0 selects 1/16
// - in rmw, writes increment column, reads leave it
// - end leaves rmw and restores saved column
// - soft reset sets start line 0 and page 3, memory kept
module lcdd_decoder #(
	parameter int COLS = 80,
	parameter int BUSY_CYC = (`LCDD_BUSY_NS + `LCDD_CLK_NS - 1) / `LCDD_CLK_NS,
	parameter int INIT_CYC = (`LCDD_INIT_NS + `LCDD_CLK_NS - 1) / `LCDD_CLK_NS
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic bus_type68,
	input wire logic rst_pin_n,
	input wire logic cmd_data_select,
	input wire logic strobe_rd_e,
	input wire logic strobe_wr_rw,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic [31:0] common_driver,
	output logic segment_driver,
	output logic [6:0] segment_index,
	output logic power_save
);
	if (COLS < 1 || COLS > 80 || BUSY_CYC < 1 || BUSY_CYC > 255 || INIT_CYC < 1 || INIT_CYC > 255) begin : g_bad
		$error("lcdd_decoder: parameter out of range");
	end
	localparam logic [7:0] BUSY_LD = 8'(BUSY_CYC);
	localparam logic [7:0] INIT_LD = 8'(INIT_CYC);

	// pin synchronisers, a change counts once stages two and three agree
	logic [3:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d;
	logic [7:0] d1_q, d2_q, d3_q;
	logic type68_q;
	assign pin_raw = {rst_pin_n, cmd_data_select, strobe_rd_e, strobe_wr_rw};
	always_ff @(posedge clock) begin
		s1_q <= pin_raw;
		s2_q <= s1_q;
		s3_q <= s2_q;
		d1_q <= data_in;
		d2_q <= d1_q;
		d3_q <= d2_q;
		if (srst) begin
			type68_q <= bus_type68;
		end
	end
	for (genvar i = 0; i < 4; i++) begin : g_pin
		always_comb begin
			pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
		end
		always_ff @(posedge clock) begin
			pin_q[i] <= srst ? s3_q[i] : pin_d[i];
		end
	end

	// host bus phases
	lcdd_pkg::lcdd_phase_type ph_q, ph_d;
	logic a0_q, a0_d, oe_q, oe_d, active, is_rd, hw_rst;
	logic [7:0] wdat_q, wdat_d, dout_q, dout_d, status, rlatch_q, rlatch_d;
	logic fin_wr, fin_rd, cmd_go, dwr_go, drd_go;
	always_comb begin
		active = type68_q ? pin_q[`LCDD_PIN_SA] : ~(pin_q[`LCDD_PIN_SA] & pin_q[`LCDD_PIN_SB]);
		is_rd = type68_q ? pin_q[`LCDD_PIN_SB] : ~pin_q[`LCDD_PIN_SA];
		hw_rst = ~pin_q[`LCDD_PIN_RSTN];
		ph_d = ph_q;
		unique case (ph_q)
			lcdd_pkg::LCDD_PH_IDLE: begin
				if (active) begin
					ph_d = is_rd ? lcdd_pkg::LCDD_PH_RD : lcdd_pkg::LCDD_PH_WR;
				end
			end
			lcdd_pkg::LCDD_PH_WR, lcdd_pkg::LCDD_PH_RD: begin
				if (!active) begin
					ph_d = lcdd_pkg::LCDD_PH_IDLE;
				end
			end
			default: ph_d = lcdd_pkg::LCDD_PH_IDLE;
		endcase
		fin_wr = (ph_q == lcdd_pkg::LCDD_PH_WR) && !active;
		fin_rd = (ph_q == lcdd_pkg::LCDD_PH_RD) && !active;
		cmd_go = fin_wr && !a0_q && !hw_rst;
		dwr_go = fin_wr && a0_q && !hw_rst;
		drd_go = fin_rd && a0_q && !hw_rst;
		a0_d = active ? pin_q[`LCDD_PIN_A0] : a0_q;
		wdat_d = (active && !is_rd && d2_q == d3_q) ? d3_q : wdat_q;
		oe_d = (ph_d == lcdd_pkg::LCDD_PH_RD);
		dout_d = dout_q;
		if (ph_q == lcdd_pkg::LCDD_PH_IDLE && active && is_rd) begin
			// data reads present the holding latch, so one read lags
			dout_d = pin_q[`LCDD_PIN_A0] ? rlatch_q : status;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			ph_q <= lcdd_pkg::LCDD_PH_IDLE;
			{a0_q, oe_q} <= 2'h0;
			{wdat_q, dout_q} <= 16'h0000;
		end else begin
			ph_q <= ph_d;
			{a0_q, oe_q} <= {a0_d, oe_d};
			{wdat_q, dout_q} <= {wdat_d, dout_d};
		end
	end

	// command and address state
	logic disp_q, disp_d, stat_q, stat_d, psave_q, psave_d, adc_q, adc_d;
	logic duty32_q, duty32_d, rmw_q, rmw_d, wpend_q, wpend_d;
	logic [4:0] line_q, line_d;
	logic [1:0] page_q, page_d, wpg_q, wpg_d;
	logic [6:0] col_q, col_d, save_q, save_d, wcol_q, wcol_d, col_inc;
	logic [7:0] wbuf_q, wbuf_d, busy_q, busy_d, init_q, init_d;
	logic [7:0] hr_data, sr_data;
	logic [7:0] cmd;
	logic busy;
	always_comb begin
		cmd = wdat_q;
		busy = (busy_q != 8'h00) || (init_q != 8'h00);
		status = {busy, adc_q, ~disp_q, init_q != 8'h00, `LCDD_STAT_LOW};
		col_inc = (col_q != `LCDD_COL_STOP) ? 7'(col_q + 7'h01) : col_q;
		{disp_d, stat_d, psave_d, adc_d, duty32_d, rmw_d} = {disp_q, stat_q, psave_q, adc_q, duty32_q, rmw_q};
		{line_d, page_d, col_d, save_d} = {line_q, page_q, col_q, save_q};
		{wpend_d, wpg_d, wcol_d, wbuf_d, rlatch_d} = {wpend_q, wpg_q, wcol_q, wbuf_q, rlatch_q};
		busy_d = (busy_q != 8'h00) ? 8'(busy_q - 8'h01) : busy_q;
		init_d = (init_q != 8'h00) ? 8'(init_q - 8'h01) : init_q;
		if (cmd_go || dwr_go || drd_go) begin
			busy_d = BUSY_LD;
		end
		if (hw_rst) begin
			{disp_d, stat_d, psave_d, rmw_d} = 4'h0;
			{adc_d, duty32_d} = 2'h3;
			{line_d, page_d, col_d} = {`LCDD_LINE_INIT, `LCDD_PAGE_INIT, `LCDD_COL_INIT};
			init_d = INIT_LD;
		end else if (cmd_go) begin
			if (cmd[`LCDD_F_OP7] == `LCDD_OP_DISP) begin
				disp_d = cmd[`LCDD_F_D0];
				if (cmd[`LCDD_F_D0]) begin
					psave_d = 1'b0;
				end else if (stat_q) begin
					psave_d = 1'b1;
				end
			end else if (cmd[`LCDD_F_OP7] == `LCDD_OP_ADC) begin
				adc_d = ~cmd[`LCDD_F_D0];
			end else if (cmd[`LCDD_F_OP7] == `LCDD_OP_STATIC) begin
				stat_d = cmd[`LCDD_F_D0];
				if (!cmd[`LCDD_F_D0]) begin
					psave_d = 1'b0;
				end else if (!disp_q) begin
					psave_d = 1'b1;
				end
			end else if (cmd[`LCDD_F_OP7] == `LCDD_OP_DUTY) begin
				duty32_d = cmd[`LCDD_F_D0];
			end else if (cmd[`LCDD_F_OP3] == `LCDD_OP_LINE) begin
				line_d = cmd[`LCDD_F_LINE];
			end else if (cmd[`LCDD_F_OP6] == `LCDD_OP_PAGE) begin
				page_d = cmd[`LCDD_F_PAGE];
			end else if (cmd == `LCDD_CMD_RMW) begin
				rmw_d = 1'b1;
				save_d = col_q;
			end else if (cmd == `LCDD_CMD_END) begin
				if (rmw_q) begin
					rmw_d = 1'b0;
					col_d = save_q;
				end
			end else if (cmd == `LCDD_CMD_SRST) begin
				{line_d, page_d} = {`LCDD_LINE_INIT, `LCDD_PAGE_INIT};
				init_d = INIT_LD;
			end else if (cmd[`LCDD_F_MSB] == `LCDD_OP_COL) begin
				col_d = cmd[`LCDD_F_COL];
			end
		end else if (dwr_go) begin
			// previous byte commits now, this one waits in the latch
			wpend_d = 1'b1;
			wbuf_d = cmd;
			wpg_d = page_q;
			wcol_d = col_q;
			col_d = col_inc;
		end else if (drd_go) begin
			rlatch_d = hr_data;
			if (!rmw_q) begin
				col_d = col_inc;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			{disp_q, stat_q, psave_q, rmw_q, wpend_q} <= 5'h00;
			{adc_q, duty32_q} <= 2'h3;
			{line_q, page_q, col_q} <= {`LCDD_LINE_INIT, `LCDD_PAGE_INIT, `LCDD_COL_INIT};
			{save_q, wcol_q, wpg_q} <= 16'h0000;
			{wbuf_q, rlatch_q, busy_q} <= 24'h00_0000;
			init_q <= INIT_LD;
		end else begin
			{disp_q, stat_q, psave_q, rmw_q, wpend_q} <= {disp_d, stat_d, psave_d, rmw_d, wpend_d};
			{adc_q, duty32_q} <= {adc_d, duty32_d};
			{line_q, page_q, col_q} <= {line_d, page_d, col_d};
			{save_q, wcol_q, wpg_q} <= {save_d, wcol_d, wpg_d};
			{wbuf_q, rlatch_q, busy_q} <= {wbuf_d, rlatch_d, busy_d};
			init_q <= init_d;
		end
	end

	// display scan: start line plus common index, page register unused
	logic [6:0] seg_q, seg_d, scol;
	logic [4:0] com_q, com_d, mline;
	logic [5:0] lines;
	logic [31:0] cdrv_q, cdrv_d;
	logic sdrv_q, sdrv_d;
	logic [6:0] sidx_q, sidx_d;
	always_comb begin
		lines = duty32_q ? `LCDD_LINES32 : `LCDD_LINES16;
		mline = 5'(line_q + com_q);
		scol = adc_q ? seg_q : 7'(`LCDD_COL_LAST - seg_q);
		seg_d = 7'(seg_q + 7'h01);
		com_d = com_q;
		if (seg_q == `LCDD_COL_LAST) begin
			seg_d = 7'h00;
			com_d = (6'({1'b0, com_q} + 6'h01) >= lines) ? 5'h00 : 5'(com_q + 5'h01);
		end
		sidx_d = seg_q;
		if (psave_q) begin
			sdrv_d = 1'b0;
			cdrv_d = 32'h0000_0000;
		end else if (stat_q) begin
			sdrv_d = 1'b1;
			cdrv_d = 32'hFFFF_FFFF;
		end else begin
			sdrv_d = disp_q & sr_data[mline[`LCDD_F_LBIT]];
			cdrv_d = `LCDD_COM_ONE << com_q;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			{seg_q, com_q, sidx_q, sdrv_q} <= 20'h0_0000;
			cdrv_q <= 32'h0000_0000;
		end else begin
			{seg_q, com_q, sidx_q, sdrv_q} <= {seg_d, com_d, sidx_d, sdrv_d};
			cdrv_q <= cdrv_d;
		end
	end

	lcdd_ram #(.COLS(COLS), .PAGES(4)) u_ram (
		.clock(clock),
		.wr_en(dwr_go && wpend_q),
		.wr_page(wpg_q),
		.wr_col(wcol_q),
		.wr_data(wbuf_q),
		.hr_page(page_q),
		.hr_col(col_q),
		.hr_data(hr_data),
		.sr_page(mline[`LCDD_F_LPAGE]),
		.sr_col(scol),
		.sr_data(sr_data)
	);

	assign data_out = dout_q;
	assign data_oe = oe_q;
	assign common_driver = cdrv_q;
	assign segment_driver = sdrv_q;
	assign segment_index = sidx_q;
	assign power_save = psave_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_COL_STOP: assert property (
		(dwr_go || (drd_go && !rmw_q)) && col_q == `LCDD_COL_STOP |=> col_q == `LCDD_COL_STOP && $stable(page_q))
		else $error("column moved past its stop");
	AST_WRITE_INC: assert property (
		dwr_go && col_q != `LCDD_COL_STOP |=> col_q == 7'($past(col_q) + 7'h01) && wbuf_q == $past(wdat_q))
		else $error("data write did not latch and advance");
	AST_READ_INC: assert property (
		drd_go && !rmw_q && col_q != `LCDD_COL_STOP |=> col_q == 7'($past(col_q) + 7'h01))
		else $error("data read did not advance column");
	AST_RMW_READ: assert property (
		drd_go && rmw_q |=> $stable(col_q) ##1 $stable(col_q) || $past(cmd_go))
		else $error("read in rmw mode moved column");
	AST_END_RESTORE: assert property (
		cmd_go && cmd == `LCDD_CMD_END && rmw_q |=> !rmw_q && col_q == $past(save_q))
		else $error("end did not restore column");
	AST_PSAVE_ENTER: assert property (
		cmd_go && cmd[`LCDD_F_OP7] == `LCDD_OP_DISP && !cmd[`LCDD_F_D0] && stat_q |=> psave_q ##1 power_save)
		else $error("power save not entered");
	AST_PSAVE_EXIT: assert property (
		cmd_go && cmd[`LCDD_F_OP7] == `LCDD_OP_STATIC && !cmd[`LCDD_F_D0] |=> !psave_q ##1 !power_save)
		else $error("power save not left");
	AST_SOFT_RESET: assert property (
		cmd_go && cmd == `LCDD_CMD_SRST |=> line_q == `LCDD_LINE_INIT && page_q == `LCDD_PAGE_INIT && init_q == INIT_LD)
		else $error("soft reset values wrong");
	AST_STATUS: assert property (
		ph_q == lcdd_pkg::LCDD_PH_IDLE && active && is_rd && !pin_q[`LCDD_PIN_A0]
		|=> data_out[3:0] == `LCDD_STAT_LOW && data_out[7] == $past(busy) && data_out[5] == !$past(disp_q))
		else $error("status byte wrong");
	AST_BUSY: assert property (
		cmd_go || dwr_go || drd_go |=> busy [*2])
		else $error("busy not shown after operation");
	AST_DUTY16: assert property (
		!duty32_q && seg_q == `LCDD_COL_LAST && com_q == `LCDD_COM_LAST16 |=> com_q == 5'h00)
		else $error("1/16 duty did not wrap");
	AST_STATIC: assert property (
		stat_q && !psave_q |=> common_driver == 32'hFFFF_FFFF && segment_driver)
		else $error("static drive not forcing outputs");

	CVR_RMW_END: cover property (cmd_go && cmd == `LCDD_CMD_RMW ##[1:200] cmd_go && cmd == `LCDD_CMD_END);
	CVR_WRITE_COMMIT: cover property (dwr_go && wpend_q);
	CVR_PSAVE: cover property ($rose(psave_q));
	CVR_STOP: cover property (dwr_go && col_q == `LCDD_COL_STOP);
endmodule
`default_nettype wire

// file: sim/lcdd_host_model.sv
// host processor model driving the 8-bit parallel bus of the decoder
`timescale 1ns/100ps
`default_nettype none
module lcdd_host_model (
	input wire logic clock,
	input wire logic mode68,
	output logic cmd_data_select,
	output logic strobe_rd_e,
	output logic strobe_wr_rw,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe
);
	logic oe_seen = 1'b0;
	initial begin
		cmd_data_select = 1'b0;
		strobe_rd_e = 1'b1;
		strobe_wr_rw = 1'b1;
		data_in = 8'h00;
	end
	task automatic idle();
		strobe_rd_e = ~mode68;
		strobe_wr_rw = 1'b1;
	endtask
	// select and direction settle a cycle before the strobe and outlast it
	task automatic access(input logic a0, input logic rd, input logic [7:0] wd, output logic [7:0] rv);
		@(negedge clock);
		cmd_data_select = a0;
		strobe_wr_rw = mode68 ? rd : 1'b1;
		data_in = rd ? ~data_in : wd;
		@(negedge clock);
		if (mode68) strobe_rd_e = 1'b1;
		else if (rd) strobe_rd_e = 1'b0;
		else strobe_wr_rw = 1'b0;
		repeat (7) @(negedge clock);
		rv = data_out;
		oe_seen = data_oe;
		strobe_rd_e = ~mode68;
		if (!mode68) strobe_wr_rw = 1'b1;
		repeat (3) @(negedge clock);
		strobe_wr_rw = 1'b1;
		// released bus shows the inverse, not the last value
		data_in = ~data_in;
		repeat (6) @(negedge clock);
	endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench of the lcd instruction decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int INIT = 40;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic bus_type68 = 1'b0;
	logic rst_pin_n = 1'b1;
	logic cmd_data_select;
	logic strobe_rd_e;
	logic strobe_wr_rw;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe;
	logic [31:0] common_driver;
	logic segment_driver;
	logic [6:0] segment_index;
	logic power_save;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	int seed;
	int p;
	int c;
	logic [7:0] mem [4][80];
	logic [7:0] rv;
	logic [7:0] d;
	logic [4:0] line;
	logic ord;
	logic on;
	logic stat;
	logic d32;
	always #50 clock = ~clock;
	lcdd_decoder #(.INIT_CYC(INIT)) u_lcdd_decoder (.clock(clock), .srst(srst), .bus_type68(bus_type68),
		.rst_pin_n(rst_pin_n), .cmd_data_select(cmd_data_select), .strobe_rd_e(strobe_rd_e),
		.strobe_wr_rw(strobe_wr_rw), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.common_driver(common_driver), .segment_driver(segment_driver), .segment_index(segment_index),
		.power_save(power_save));
	lcdd_host_model u_lcdd_host_model (.clock(clock), .mode68(bus_type68), .cmd_data_select(cmd_data_select),
		.strobe_rd_e(strobe_rd_e), .strobe_wr_rw(strobe_wr_rw), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe));
	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmd(logic [7:0] v);
		u_lcdd_host_model.access(1'b0, 1'b0, v, rv);
	endtask
	task automatic wr(logic [7:0] v);
		u_lcdd_host_model.access(1'b1, 1'b0, v, rv);
	endtask
	task automatic rd();
		u_lcdd_host_model.access(1'b1, 1'b1, 8'h00, rv);
	endtask
	function automatic logic [7:0] exp_status(logic busy, logic rs);
		return {busy, ord, ~on, rs, 4'h0};
	endfunction
	function automatic logic exp_pixel(int k, int n);
		int l;
		int cl;
		l = (int'(line) + k) % 32;
		cl = ord ? n : 79 - n;
		return on & mem[l / 8][cl][l % 8];
	endfunction
	task automatic status(logic busy, logic rs);
		u_lcdd_host_model.access(1'b0, 1'b1, 8'h00, rv);
		chk("status", rv, exp_status(busy, rs));
		chk("oe_read", u_lcdd_host_model.oe_seen, 1);
		chk("oe_idle", data_oe, 0);
	endtask
	task automatic readback(int pg, int c0, int n);
		cmd({6'h2E, pg[1:0]});
		cmd({1'b0, c0[6:0]});
		rd();
		for (int i = 0; i < n; i++) begin
			rd();
			chk("data", rv, (c0 + i < 80) ? mem[pg][c0 + i] : 8'h00);
		end
		cmd({1'b0, c0[6:0]});
		rd();
		rd();
		chk("page", rv, mem[pg][c0]);
	endtask
	task automatic scan(int n);
		int k;
		int pi;
		pi = -1;
		repeat (4) @(negedge clock);
		repeat (n) begin
			@(negedge clock);
			if (pi >= 0) chk("idx", segment_index, (pi + 1) % 80);
			pi = segment_index;
			if (stat) begin
				chk("com", common_driver, 32'hFFFF_FFFF);
				chk("seg", segment_driver, 1);
			end else begin
				k = 0;
				for (int i = 0; i < 32; i++) if (common_driver[i]) k = i;
				chk("com", common_driver, 32'h0000_0001 << k);
				chk("duty", k < (d32 ? 32 : 16), 1);
				chk("seg", segment_driver, exp_pixel(k, segment_index));
			end
		end
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 80000) begin
			miscompares++;
			$display("Error timeout expected done seen hang");
			print_verdict();
		end
	end
	initial begin
		seed = $urandom(30910);
		for (int m = 0; m < 2; m++) begin
			bus_type68 = m[0];
			u_lcdd_host_model.idle();
			srst = 1'b1;
			repeat (6) @(negedge clock);
			srst = 1'b0;
			ord = 1;
			on = 0;
			stat = 0;
			d32 = 1;
			line = 0;
			status(1, 1);
			repeat (INIT + 20) @(negedge clock);
			status(0, 0);
			cmd(8'hAF);
			on = 1;
			status(0, 0);
			rst_pin_n = 1'b0;
			repeat (10) @(negedge clock);
			rst_pin_n = 1'b1;
			on = 0;
			status(1, 1);
			repeat (INIT + 20) @(negedge clock);
			for (int pg = 0; pg < 4; pg++) begin
				cmd({6'h2E, pg[1:0]});
				cmd(8'h00);
				for (int i = 0; i < 81; i++) begin
					d = 8'($urandom);
					if (i < 80) mem[pg][i] = d;
					wr(d);
				end
			end
			for (int pg = 0; pg < 4; pg++) readback(pg, 0, 81);
			readback(3, 8'h4E, 3);
			cmd(8'hAF);
			on = 1;
			line = 5'($urandom);
			cmd({3'h6, line});
			cmd(8'hA1);
			ord = 0;
			cmd(8'hA9);
			status(0, 0);
			scan(2700);
			cmd(8'hA0);
			ord = 1;
			cmd(8'hA8);
			d32 = 0;
			repeat (2600) @(negedge clock);
			scan(1400);
			cmd(8'hAE);
			on = 0;
			scan(100);
			cmd(8'hA5);
			stat = 1;
			chk("ps", power_save, 1);
			chk("com", common_driver, 0);
			cmd(8'hAF);
			on = 1;
			chk("ps", power_save, 0);
			scan(100);
			cmd(8'hAE);
			on = 0;
			chk("ps", power_save, 1);
			cmd(8'hA4);
			stat = 0;
			chk("ps", power_save, 0);
			cmd(8'hAF);
			on = 1;
			p = $urandom_range(2, 0);
			c = $urandom_range(77, 0);
			cmd({6'h2E, p[1:0]});
			cmd({1'b0, c[6:0]});
			// no column command from here until the end command
			cmd(8'hE0);
			rd();
			repeat (2) begin
				rd();
				chk("rmw", rv, mem[p][c]);
			end
			wr(8'($urandom));
			wr(8'($urandom));
			cmd(8'hEE);
			for (int i = 0; i < 3; i++) begin
				d = 8'($urandom);
				mem[p][c + i] = d;
				wr(d);
			end
			readback(p, c, 2);
			cmd(8'hB8);
			line = 5'h07;
			cmd(8'hC7);
			cmd(8'hE2);
			line = 0;
			status(1, 1);
			repeat (INIT + 20) @(negedge clock);
			cmd(8'h0A);
			d = 8'($urandom);
			mem[3][10] = d;
			wr(d);
			wr(~d);
			readback(3, 10, 1);
			scan(300);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
